/* File: core/rxafc_pkg.sv */
package rxafc_pkg;

  // register map
  localparam logic [7:0] RXAFC_CFG_OFFSET = 8'hac;
  localparam logic [7:0] RXAFC_STAT_OFFSET = 8'hb8;
  localparam logic [31:0] RXAFC_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] RXAFC_CFG_WMASK = 32'h00ff_ffff;

  // field positions
  localparam int RXAFC_HI_LSB = 16;
  localparam int RXAFC_LO_LSB = 8;
  localparam int RXAFC_DUR_LSB = 4;
  localparam int RXAFC_MULT_BIT = 3;
  localparam int RXAFC_BRD_BIT = 2;
  localparam int RXAFC_ADD_BIT = 1;
  localparam int RXAFC_ANY_BIT = 0;

  // fifo level unit in bytes, as a shift
  localparam int RXAFC_UNIT_SHIFT = 6;

  // timing at 100 MHz core clock
  localparam int RXAFC_CLK_MHZ = 100;
  localparam int RXAFC_US_CYCLES = RXAFC_CLK_MHZ;
  // 10 Mb/s adds 2.2 us to every code
  localparam int RXAFC_SLOW_EXTRA_NS = 2200;
  localparam int RXAFC_SLOW_EXTRA_CYC = (RXAFC_SLOW_EXTRA_NS * RXAFC_CLK_MHZ) / 1000;

  // jam duration per code, in microseconds at 100 Mb/s
  localparam int RXAFC_DUR_US [16] = '{5, 10, 15, 25, 50, 100, 150, 200,
                                       250, 300, 350, 400, 450, 500, 550, 600};

  typedef enum logic [1:0]
  {
    RXAFC_IDLE = 2'b00,
    RXAFC_PAUSED = 2'b01
  } rxafc_state_type;

  // frame event from the receive filter
  typedef struct packed
  {
    logic start;
    logic multicast;
    logic broadcast;
    logic own_addr;
  } rxafc_frame_type;

  // request toward the mac transmitter
  typedef struct packed
  {
    logic pause_req;
    logic [15:0] pause_time;
  } rxafc_pause_type;

endpackage

/* File: core/rxafc_jam_timer.sv */
`timescale 1ns/1ps
module rxafc_jam_timer
  import rxafc_pkg::*;
#(
  parameter int CNT_W = 17
)
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // control
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [3:0] i_code,
  input wire logic i_slow,
  // status
  output logic o_busy
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] load_w;
  logic [31:0] cycles_w;

  // lookup table of durations, 10 Mb/s adds a fixed tail
  assign cycles_w = 32'(RXAFC_DUR_US[i_code] * RXAFC_US_CYCLES)
                  + (i_slow ? 32'(RXAFC_SLOW_EXTRA_CYC) : 32'h0000_0000);
  assign load_w = cycles_w[CNT_W-1:0];

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || i_abort)
    begin
      cnt_q <= '0;
    end
    else if (i_start)
    begin
      cnt_q <= load_w;
    end
    else if (cnt_q != '0)
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_busy = (cnt_q != '0);

endmodule

/* File: core/rxafc_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - no pause frames or jamming while the mac transmitter is disabled.
// - high threshold, bits 23:16, in 64-byte units, triggers flow control.
// - full duplex with bit 0 set sends exactly one pause frame per high-threshold crossing.
// - pause frame carries the mac pause time value.
// - half duplex jams each matching frame above high threshold for duration.
// - low threshold, bits 15:8, sends zero-time pause when level drops below.
// - resume frame only after a pause was sent and while enabled.
// - duration code in bits 7:4 selects jam hold time.
// - duration code is ignored in full duplex.
// - bit 3 jams multicast frames above threshold, half duplex only.
// - bit 2 jams broadcast frames above threshold, half duplex only.
// - bit 1 jams own-address frames above threshold, half duplex only.
// - bit 0 overrides 3:1; any preamble jams, full duplex pauses at once.
// - duration codes 0h..Fh map 5us..600us, 10 Mb/s adds 2.2us.
module rxafc_top
  import rxafc_pkg::*;
#(
  parameter int LEVEL_W = 14
)
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // mac status
  input wire logic i_tx_enable,
  input wire logic i_full_duplex,
  input wire logic i_speed_10,
  input wire logic [15:0] i_pause_time_value,
  // receive side
  input wire logic [LEVEL_W-1:0] i_rx_fifo_bytes,
  input wire rxafc_frame_type i_frame,
  // mac transmitter requests
  output rxafc_pause_type o_pause,
  input wire logic i_pause_ack,
  output logic o_jam
);

  // ****************************************
  // configuration register
  // ****************************************
  logic [31:0] cfg_q;
  logic [31:0] rdata_q;
  logic cfg_sel_w;
  logic stat_sel_w;
  logic [31:0] stat_w;

  assign cfg_sel_w = (i_addr == RXAFC_CFG_OFFSET);
  assign stat_sel_w = (i_addr == RXAFC_STAT_OFFSET);

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      cfg_q <= RXAFC_CFG_RESET;
    end
    else if (i_wr && cfg_sel_w)
    begin
      cfg_q <= i_wdata & RXAFC_CFG_WMASK;
    end
  end

  // ****************************************
  // field decode
  // ****************************************
  logic [7:0] hi_w;
  logic [7:0] lo_w;
  logic [3:0] dur_w;
  logic mult_w;
  logic brd_w;
  logic add_w;
  logic any_w;
  logic afc_en_w;

  assign hi_w = cfg_q[RXAFC_HI_LSB +: 8];
  assign lo_w = cfg_q[RXAFC_LO_LSB +: 8];
  assign dur_w = cfg_q[RXAFC_DUR_LSB +: 4];
  assign mult_w = cfg_q[RXAFC_MULT_BIT];
  assign brd_w = cfg_q[RXAFC_BRD_BIT];
  assign add_w = cfg_q[RXAFC_ADD_BIT];
  assign any_w = cfg_q[RXAFC_ANY_BIT];
  assign afc_en_w = |cfg_q[3:0];

  // ****************************************
  // fifo level compare
  // ****************************************
  logic [LEVEL_W-1:0] units_w;
  logic [LEVEL_W-1:0] hi_ext_w;
  logic [LEVEL_W-1:0] lo_ext_w;
  logic at_high_w;
  logic below_low_w;

  // fifo count is a same-clock input, no synchroniser needed
  assign units_w = i_rx_fifo_bytes >> RXAFC_UNIT_SHIFT;
  assign hi_ext_w = LEVEL_W'(hi_w);
  assign lo_ext_w = LEVEL_W'(lo_w);
  assign at_high_w = (units_w >= hi_ext_w);
  assign below_low_w = (units_w < lo_ext_w);

  // ****************************************
  // full duplex pause control
  // ****************************************
  rxafc_state_type state_q;
  rxafc_state_type state_d;
  logic req_q;
  logic [15:0] ptime_q;
  logic fd_active_w;
  logic send_pause_w;
  logic send_resume_w;
  logic req_d;
  logic [15:0] ptime_d;
  logic resume_q;
  logic resume_d;
  logic sent_q;
  logic sent_d;
  logic pause_done_w;

  // full duplex pause needs the any-frame bit
  assign fd_active_w = i_full_duplex && any_w && i_tx_enable;
  assign send_pause_w = fd_active_w && (state_q == RXAFC_IDLE) && at_high_w
                      && !req_q;
  assign send_resume_w = i_full_duplex && afc_en_w && i_tx_enable && sent_q
                       && (state_q == RXAFC_PAUSED) && below_low_w && !req_q;
  // only an acknowledged pause counts as sent; one dropped with tx off
  // never reached the wire, so it earns no resume
  assign pause_done_w = req_q && i_pause_ack && !resume_q;
  assign sent_d = (state_q == RXAFC_PAUSED) && (sent_q || pause_done_w);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      RXAFC_IDLE:
      begin
        if (send_pause_w)
        begin
          state_d = RXAFC_PAUSED;
        end
      end
      RXAFC_PAUSED:
      begin
        // a pause lost to a disabled transmitter re-arms the crossing
        if (send_resume_w || !afc_en_w || !i_full_duplex
            || (!i_tx_enable && !sent_q && !pause_done_w))
        begin
          state_d = RXAFC_IDLE;
        end
      end
      default:
      begin
        state_d = RXAFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_q <= RXAFC_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      sent_q <= 1'b0;
    end
    else
    begin
      sent_q <= sent_d;
    end
  end

  // ****************************************
  // pause request register
  // ****************************************

  // request stands until the mac takes it; dropped if tx goes away
  always_comb
  begin
    req_d = req_q;
    ptime_d = ptime_q;
    resume_d = resume_q;
    if (!i_tx_enable)
    begin
      req_d = 1'b0;
      ptime_d = 16'h0000;
    end
    else if (send_pause_w)
    begin
      req_d = 1'b1;
      ptime_d = i_pause_time_value;
      resume_d = 1'b0;
    end
    else if (send_resume_w)
    begin
      req_d = 1'b1;
      ptime_d = 16'h0000;
      resume_d = 1'b1;
    end
    else if (i_pause_ack)
    begin
      req_d = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      req_q <= 1'b0;
      ptime_q <= 16'h0000;
      resume_q <= 1'b0;
    end
    else
    begin
      req_q <= req_d;
      ptime_q <= ptime_d;
      resume_q <= resume_d;
    end
  end

  assign o_pause.pause_req = req_q;
  assign o_pause.pause_time = ptime_q;

  // ****************************************
  // half duplex back pressure
  // ****************************************
  logic match_w;
  logic jam_start_w;
  logic jam_busy_w;
  logic jam_q;

  // any-frame wins over the filtered choices
  assign match_w = any_w || (mult_w && i_frame.multicast)
                 || (brd_w && i_frame.broadcast)
                 || (add_w && i_frame.own_addr);
  assign jam_start_w = !i_full_duplex && i_tx_enable && at_high_w
                     && i_frame.start && match_w;

  rxafc_jam_timer #(
    .CNT_W(17)
  ) u_jam_timer (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_start(jam_start_w),
    .i_abort(i_full_duplex || !i_tx_enable),
    .i_code(dur_w),
    .i_slow(i_speed_10),
    .o_busy(jam_busy_w)
  );

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      jam_q <= 1'b0;
    end
    else
    begin
      jam_q <= jam_busy_w && !i_full_duplex && i_tx_enable;
    end
  end

  assign o_jam = jam_q;

  // ****************************************
  // read back
  // ****************************************
  assign stat_w = {28'h0000000, jam_q, req_q, at_high_w, state_q == RXAFC_PAUSED};

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (i_rd && cfg_sel_w)
    begin
      rdata_q <= cfg_q;
    end
    else if (i_rd && stat_sel_w)
    begin
      rdata_q <= stat_w;
    end
    else
    begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign o_rdata = rdata_q;

endmodule

/* File: dv/rxafc_mac_model.sv */
`timescale 1ns/1ps
module rxafc_mac_model
  import rxafc_pkg::*;
(
  // mac transmitter side
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire rxafc_pause_type i_pause,
  input wire logic [3:0] i_wait,
  output logic o_ack
);
  logic [3:0] w_q;
  // a busy transmitter takes the request late
  always_ff @(posedge i_core_clk)
  begin
    w_q <= w_q + 4'h1;
    o_ack <= 1'b0;
    if (i_rst || !i_pause.pause_req || o_ack)
      w_q <= 4'h0;
    else if (w_q == i_wait)
      o_ack <= 1'b1;
  end
endmodule

/* File: dv/rxafc_chk.sv */
`timescale 1ns/1ps
module rxafc_chk
  import rxafc_pkg::*;
#(
  parameter int LEVEL_W = 14
)
(
  // watched ports
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_tx_enable,
  input wire logic i_full_duplex,
  input wire logic [15:0] i_pause_time_value,
  input wire logic [LEVEL_W-1:0] i_rx_fifo_bytes,
  input wire rxafc_frame_type i_frame,
  input wire rxafc_pause_type o_pause,
  input wire logic i_pause_ack,
  input wire logic o_jam
);
  logic [31:0] cfg_q;
  wire logic [LEVEL_W-1:0] units_w = i_rx_fifo_bytes >> RXAFC_UNIT_SHIFT;
  wire logic hi_w = units_w >= LEVEL_W'(cfg_q[23:16]);
  wire logic lo_w = units_w < LEVEL_W'(cfg_q[15:8]);
  wire logic f_w = i_frame.start && (cfg_q[0] ||
    (|(cfg_q[3:1] & {i_frame.multicast, i_frame.broadcast, i_frame.own_addr})));
  wire logic ok_w = i_tx_enable && !i_full_duplex;
  wire logic rq_w = o_pause.pause_req;
  // shadow of the config register
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      cfg_q <= RXAFC_CFG_RESET;
    else if (i_wr && i_addr == RXAFC_CFG_OFFSET)
      cfg_q <= i_wdata & RXAFC_CFG_WMASK;
  end
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  property p_tx_off;
    !i_tx_enable |=> !o_jam && !rq_w;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("active with tx off");
  property p_fd_jam;
    i_full_duplex |=> !o_jam;
  endproperty
  a_fd_jam: assert property (p_fd_jam) else $error("jam in full duplex");
  property p_jam_go;
    ok_w && hi_w && f_w ##1 ok_w |=> o_jam;
  endproperty
  a_jam_go: assert property (p_jam_go) else $error("no jam on match");
  property p_jam_why;
    $rose(o_jam) |-> $past(f_w && hi_w, 2);
  endproperty
  a_jam_why: assert property (p_jam_why) else $error("jam without cause");
  property p_req_why;
    $rose(rq_w) |-> $past(i_full_duplex && i_tx_enable && (|cfg_q[3:0]));
  endproperty
  a_req_why: assert property (p_req_why) else $error("pause without cause");
  property p_ptime;
    $rose(rq_w) && $past(hi_w) |-> $past(cfg_q[0]) &&
      o_pause.pause_time == $past(i_pause_time_value);
  endproperty
  a_ptime: assert property (p_ptime) else $error("pause time wrong");
  property p_resume;
    $rose(rq_w) && !$past(hi_w) |-> $past(lo_w) && o_pause.pause_time == 16'h0;
  endproperty
  a_resume: assert property (p_resume) else $error("resume wrong");
  property p_hold;
    rq_w && !i_pause_ack && i_tx_enable && i_full_duplex |=> rq_w;
  endproperty
  a_hold: assert property (p_hold) else $error("pause dropped early");
  property p_ack;
    rq_w && i_pause_ack |=> !rq_w;
  endproperty
  a_ack: assert property (p_ack) else $error("pause kept after ack");
  property p_rd;
    i_rd && i_addr == RXAFC_CFG_OFFSET |=> o_rdata == cfg_q;
  endproperty
  a_rd: assert property (p_rd) else $error("config read wrong");
endmodule

/* File: dv/rxafc_tb.sv */
`timescale 1ns/1ps
module testbench import rxafc_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tx_en = 1'b1, fd = 1'b0, slow = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] ptime = 16'h1, ltime;
  logic [13:0] bytes = 14'h0;
  logic [3:0] wait_c = 4'h0;
  rxafc_frame_type frame = 4'h0;
  rxafc_pause_type pause;
  logic ack, jam;
  int seed = 26, err_total = 0, compares = 0, npause = 0, cyc_n = 0, n;
  rxafc_top i_dut (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_tx_enable(tx_en), .i_full_duplex(fd), .i_speed_10(slow),
    .i_pause_time_value(ptime), .i_rx_fifo_bytes(bytes), .i_frame(frame), .o_pause(pause),
    .i_pause_ack(ack), .o_jam(jam));
  rxafc_mac_model i_mac (.i_core_clk(clk), .i_rst(rst), .i_pause(pause), .i_wait(wait_c),
    .o_ack(ack));
  // ********
  // helpers
  // ********
  initial
    forever #5 clk = ~clk;
  task automatic end_sim;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard, longest run is a few thousand cycles
  always @(posedge clk)
  begin
    cyc_n++;
    if (pause.pause_req && ack)
    begin
      npause++;
      ltime = pause.pause_time;
    end
    if (cyc_n == 40000)
    begin
      err_total++;
      end_sim;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [31:0] d);
    @(posedge clk);
    addr <= RXAFC_CFG_OFFSET;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  function automatic logic exp_jam(input logic [3:0] c, input logic [2:0] f, input logic d);
    return !d && (c[0] || (|(c[3:1] & f)));
  endfunction
  function automatic logic [31:0] dur(input int c, input int s);
    return RXAFC_DUR_US[c] * RXAFC_US_CYCLES + s * 220;
  endfunction
  // ********
  // tests
  // ********
  initial
  begin
    cyc(2);
    rst <= 1'b0;
    rd_reg(8'hac, 32'h0);
    wr_reg(32'hffff_feff);
    rd_reg(8'hac, 32'h00ff_feff);
    rd_reg(8'ha8, 32'h0);
    $display("register test done");
    fd <= 1'b1;
    for (int r = 0; r < 2; r++)
    begin
      wait_c <= 4'(r * 5);
      ptime <= 16'($random(seed)) | 16'h1;
      wr_reg(32'h0004_0201);
      bytes <= 14'd255;
      cyc(20);
      chk(npause, 2 * r);
      bytes <= 14'd256;
      cyc(20);
      chk(npause, 2 * r + 1);
      chk(ltime, ptime);
      bytes <= 14'h3fff;
      cyc(20);
      chk(npause, 2 * r + 1);
      rd_reg(RXAFC_STAT_OFFSET, 32'h0000_0003);
      bytes <= 14'd128;
      cyc(20);
      chk(npause, 2 * r + 1);
      bytes <= 14'd127;
      cyc(20);
      chk(npause, 2 * r + 2);
      chk(ltime, 16'h0);
    end
    tx_en <= 1'b0;
    bytes <= 14'h3fff;
    cyc(20);
    chk(npause, 4);
    $display("pause test done");
    fd <= 1'b0;
    tx_en <= 1'b1;
    for (int k = 0; k < 24; k++)
    begin
      n = $random(seed);
      wr_reg({20'h04020, 4'h0, 4'h1 << (k % 4)});
      fd <= n[3] & (k % 4 != 0);
      frame <= {1'b1, n[2:0]};
      @(posedge clk);
      frame.start <= 1'b0;
      cyc(2);
      #1;
      chk(jam, exp_jam(4'h1 << (k % 4), n[2:0], fd));
      tx_en <= 1'b0;
      cyc(1);
      tx_en <= 1'b1;
    end
    fd <= 1'b0;
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 4; c += 3)
      begin
        slow <= s[0];
        wr_reg({20'h04020, 4'(c), 4'h1});
        frame <= 4'h8;
        @(posedge clk);
        frame <= 4'h0;
        cyc(1);
        #1;
        n = 0;
        while (jam === 1'b1)
        begin
          n++;
          @(posedge clk);
          #1;
        end
        chk(n, dur(c, s));
      end
    $display("jam test done");
    end_sim;
  end
endmodule
bind rxafc_top rxafc_chk #(.LEVEL_W(LEVEL_W)) i_chk (.*);
